//--- slc_defines.svh
// constants of the security lock control block
`ifndef SLC_DEFINES_SVH
`define SLC_DEFINES_SVH

`define SLC_ROM_KEY   32'h0000_003D
`define SLC_DBG_KEY   32'h0000_00C5
`define SLC_POR_REQ   1'b1
`define SLC_RST_PEND  1'b1
`define SLC_REQ_POS   0
`define SLC_BIT_ROM   0
`define SLC_BIT_DBG   1

`endif

//--- slc_pkg.sv
// types shared by the security lock control files
package slc_pkg;

	// register addressed by a write
	typedef enum logic [1:0] {
		SLC_SEL_ROM_ARM,
		SLC_SEL_ROM_KEY,
		SLC_SEL_DBG_MODE,
		SLC_SEL_DBG_KEY
	} slc_sel_t;

	// one register write from the core
	typedef struct packed {
		logic        valid;
		slc_sel_t    sel;
		logic        word;
		logic        from_rom;
		logic [31:0] data;
	} slc_wr_t;

	// power-on domain bits, index 0 rom, index 1 debug
	typedef struct packed {
		logic [1:0] pend;
		logic [1:0] eff;
	} slc_por_t;

	// state of the main block
	typedef struct packed {
		logic rom_lock;
		logic dbg_lock;
		logic rom_grant;
		logic probe_grant;
		logic full_erase;
		logic refused;
	} slc_state_t;

endpackage

//--- slc_por_bits.sv
// request and effective lock bits held on power-on reset only
`timescale 1ns/1ps
`include "slc_defines.svh"

module slc_por_bits (
	// clock and power-on reset
	input  wire logic       sys_clk,
	input  wire logic       por_n,
	// writes of the request bits
	input  wire logic [1:0] pend_we,
	input  wire logic [1:0] pend_val,
	// key accepted: copy request into effective state
	input  wire logic [1:0] commit,
	// held bits
	output logic      [1:0] pend,
	output logic      [1:0] eff
);

	slc_pkg::slc_por_t s_q;
	slc_pkg::slc_por_t s_d;

	// request bits take writes, effective bits follow only a key
	always_comb
	begin
		s_d = s_q;
		for (int i = 0; i < 2; i++)
		begin
			if (pend_we[i])
				s_d.pend[i] = pend_val[i];
			if (commit[i])
				s_d.eff[i] = s_q.pend[i];
		end
	end

	// only power-on reset sets these, the normal reset does not
	always_ff @(posedge sys_clk or negedge por_n)
	begin
		if (!por_n)
			s_q <= {{2{`SLC_POR_REQ}}, {2{`SLC_POR_REQ}}};
		else
			s_q <= s_d;
	end

	assign pend = s_q.pend;
	assign eff  = s_q.eff;

	AST_POR_COMMIT: assert property (@(posedge sys_clk) disable iff (!por_n)
		commit[0] |=> eff[0] == $past(pend[0]))
		else $error("rom effective bit did not take request on key");

	AST_POR_DBG_HOLD: assert property (@(posedge sys_clk) disable iff (!por_n)
		!commit[1] |=> $stable(eff[1]))
		else $error("debug effective bit changed without key");

endmodule // slc_por_bits

//--- slc_lock_ctrl.sv
// ROM protection and debug-probe lock control
`timescale 1ns/1ps
`include "slc_defines.svh"

module slc_lock_ctrl (
	// clock and resets
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             por_n,
	// register writes from the core
	input  wire slc_pkg::slc_wr_t wr_req,
	// flash controller
	input  wire logic             flash_secure,
	input  wire logic             auto_erase_cmd,
	// access requests to be gated
	input  wire logic             rom_acc_req,
	input  wire logic             probe_req,
	// readable request bits (effective state)
	output logic                  rom_protect_request,
	output logic                  debug_disable_request,
	// lock levels and grants
	output logic                  rom_lock,
	output logic                  debug_lock,
	output logic                  rom_acc_grant,
	output logic                  probe_grant,
	// flash wipe and refused write
	output logic                  flash_full_erase,
	output logic                  wr_refused
);

	slc_pkg::slc_state_t s_q;
	slc_pkg::slc_state_t s_d;

	logic [1:0] pend_we;
	logic [1:0] pend_val;
	logic [1:0] commit;
	logic [1:0] pend;
	logic [1:0] eff;
	logic       rom_sel;
	logic       area_ok;
	logic       arm_wr;
	logic       mode_wr;
	logic       rkey_ok;
	logic       dkey_ok;

	// full-word write to one register in this cycle, shared by the arm, mode and key decodes
	function automatic logic word_hit(
		input slc_pkg::slc_wr_t  w,
		input slc_pkg::slc_sel_t s
	);
		return w.valid && w.word && (w.sel == s);
	endfunction

	// write decode: word size, ROM-area guard and key compare
	always_comb
	begin
		rom_sel = (wr_req.sel == slc_pkg::SLC_SEL_ROM_ARM) ||
			(wr_req.sel == slc_pkg::SLC_SEL_ROM_KEY);
		area_ok = !s_q.rom_lock || wr_req.from_rom;
		arm_wr  = word_hit(wr_req, slc_pkg::SLC_SEL_ROM_ARM) && area_ok;
		mode_wr = word_hit(wr_req, slc_pkg::SLC_SEL_DBG_MODE);
		rkey_ok = word_hit(wr_req, slc_pkg::SLC_SEL_ROM_KEY) && area_ok &&
			(wr_req.data == `SLC_ROM_KEY);
		dkey_ok = word_hit(wr_req, slc_pkg::SLC_SEL_DBG_KEY) &&
			(wr_req.data == `SLC_DBG_KEY);
	end

	// request writes and key commits toward the power-on bits
	always_comb
	begin
		pend_we = 2'h0;
		pend_val = 2'h0;
		commit = 2'h0;
		pend_we[`SLC_BIT_ROM]  = arm_wr;
		pend_we[`SLC_BIT_DBG]  = mode_wr;
		pend_val[`SLC_BIT_ROM] = wr_req.data[`SLC_REQ_POS];
		pend_val[`SLC_BIT_DBG] = wr_req.data[`SLC_REQ_POS];
		commit[`SLC_BIT_ROM]   = rkey_ok;
		commit[`SLC_BIT_DBG]   = dkey_ok;
	end

	// request and effective bits, set by power-on reset only
	slc_por_bits slc_por_bits_i (
		.sys_clk  (sys_clk),
		.por_n    (por_n),
		.pend_we  (pend_we),
		.pend_val (pend_val),
		.commit   (commit),
		.pend     (pend),
		.eff      (eff)
	);

	// next state: locks, gated grants, erase and refusal flag
	always_comb
	begin
		s_d = s_q;
		// effective bit applies whenever flash security is on
		s_d.rom_lock = flash_secure && eff[`SLC_BIT_ROM];
		s_d.dbg_lock = flash_secure && eff[`SLC_BIT_DBG];
		s_d.rom_grant = rom_acc_req && !s_d.rom_lock;
		s_d.probe_grant = probe_req && !s_d.dbg_lock;
		s_d.full_erase = auto_erase_cmd && flash_secure;
		// anything not taken, a wrong key included, is refused
		s_d.refused = wr_req.valid && !(arm_wr || mode_wr || rkey_ok || dkey_ok);
	end

	// locks come up set so nothing leaks right after reset
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '{rom_lock: 1'b1, dbg_lock: 1'b1, default: 1'b0};
		else
			s_q <= s_d;
	end

	// outputs straight from flops
	assign rom_protect_request   = eff[`SLC_BIT_ROM];
	assign debug_disable_request = eff[`SLC_BIT_DBG];
	assign rom_lock              = s_q.rom_lock;
	assign debug_lock            = s_q.dbg_lock;
	assign rom_acc_grant         = s_q.rom_grant;
	assign probe_grant           = s_q.probe_grant;
	assign flash_full_erase      = s_q.full_erase;
	assign wr_refused            = s_q.refused;

	// checks on the lock behaviour
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n || !por_n);

	AST_PROBE_BLOCK: assert property (
		debug_lock |-> !probe_grant)
		else $error("probe granted while debug lock active");

	AST_ROM_BLOCK: assert property (
		rom_lock |-> !rom_acc_grant)
		else $error("rom access granted while rom lock active");

	AST_ERASE: assert property (
		auto_erase_cmd && flash_secure |=> flash_full_erase)
		else $error("secured erase command did not wipe flash");

	AST_ERASE_CAUSE: assert property (
		flash_full_erase |-> $past(auto_erase_cmd && flash_secure))
		else $error("flash wipe without secured erase command");

	AST_ROM_ARM: assert property (
		(rkey_ok && pend[0]) ##1 flash_secure |=> rom_lock)
		else $error("rom lock not applied after request and key");

	AST_ROM_RELEASE: assert property (
		(rkey_ok && !pend[0]) |=> ##1 !rom_lock)
		else $error("rom lock not released after request and key");

	AST_DBG_ALLOW: assert property (
		(dkey_ok && !pend[1]) |=> ##1 !debug_lock)
		else $error("debug lock not released after disable and key");

	AST_DBG_REARM: assert property (
		(dkey_ok && pend[1]) ##1 flash_secure |=> debug_lock)
		else $error("debug lock not re-armed after disable and key");

	AST_READ_EFF: assert property (
		!rkey_ok |=> $stable(rom_protect_request))
		else $error("rom request readback moved without key");

	AST_ROM_AREA: assert property (
		wr_req.valid && rom_sel && rom_lock && !wr_req.from_rom |=> wr_refused)
		else $error("locked rom register accepted non-rom access");

	AST_WORD_ONLY: assert property (
		wr_req.valid && !wr_req.word |=> wr_refused && $stable(pend))
		else $error("partial write was accepted");

	AST_WRONG_KEY: assert property (
		wr_req.valid && wr_req.sel == slc_pkg::SLC_SEL_DBG_KEY &&
		wr_req.data != `SLC_DBG_KEY |=> wr_refused && $stable(debug_disable_request))
		else $error("wrong debug key changed lock state");

	// refusals, lock levels and grants traced back to their causes
	AST_ROM_WRONG_KEY: assert property (
		wr_req.valid && wr_req.sel == slc_pkg::SLC_SEL_ROM_KEY &&
		wr_req.data != `SLC_ROM_KEY |=> wr_refused && $stable(rom_protect_request))
		else $error("wrong rom key changed lock state");

	AST_REFUSE_CAUSE: assert property (
		wr_refused |-> $past(wr_req.valid))
		else $error("write refusal without a write");

	AST_ROM_FOLLOW: assert property (
		$past(rst_n) |-> rom_lock == $past(flash_secure && rom_protect_request))
		else $error("rom lock does not follow security and request bit");

	AST_DBG_FOLLOW: assert property (
		$past(rst_n) |-> debug_lock == $past(flash_secure && debug_disable_request))
		else $error("debug lock does not follow security and disable bit");

	AST_ROM_OPEN: assert property (
		rom_acc_req && !(flash_secure && rom_protect_request) |=> rom_acc_grant)
		else $error("rom access refused while rom lock released");

	AST_PROBE_OPEN: assert property (
		probe_req && !(flash_secure && debug_disable_request) |=> probe_grant)
		else $error("probe refused while debug lock released");

	AST_ROM_GRANT_CAUSE: assert property (
		rom_acc_grant |-> $past(rom_acc_req && !(flash_secure && rom_protect_request)))
		else $error("rom access granted without request or while locked");

	AST_PROBE_CAUSE: assert property (
		probe_grant |-> $past(probe_req && !(flash_secure && debug_disable_request)))
		else $error("probe granted without request or while locked");

	AST_ERASE_IGNORED: assert property (
		auto_erase_cmd && !flash_secure |=> !flash_full_erase)
		else $error("erase command wiped flash while not secured");

	// power-on bits must ride through a normal reset untouched
	AST_DBG_KEEP: assert property (@(posedge sys_clk) disable iff (!por_n)
		$fell(rst_n) && !$past(dkey_ok) |-> $stable(debug_disable_request))
		else $error("normal reset changed the debug disable bit");

	AST_ROM_KEEP: assert property (@(posedge sys_clk) disable iff (!por_n)
		$fell(rst_n) && !$past(rkey_ok) |-> $stable(rom_protect_request))
		else $error("normal reset changed the rom request bit");

endmodule // slc_lock_ctrl

//--- tb.sv
// self-checking testbench of the security lock control block
`timescale 1ns/1ps

module tb;
	logic             sys_clk        = 1'b0;
	logic             rst_n          = 1'b0;
	logic             por_n          = 1'b0;
	slc_pkg::slc_wr_t wr_req         = '0;
	logic             flash_secure   = 1'b1;
	logic             auto_erase_cmd = 1'b0;
	logic             rom_acc_req    = 1'b0;
	logic             probe_req      = 1'b0;
	logic             rom_protect_request;
	logic             debug_disable_request;
	logic             rom_lock;
	logic             debug_lock;
	logic             rom_acc_grant;
	logic             probe_grant;
	logic             flash_full_erase;
	logic             wr_refused;
	int               miscompares    = 0;
	int               checks         = 0;
	logic             rf;
	logic             e_rom          = 1'b1;
	logic             e_dbg          = 1'b1;
	logic [31:0]      rk;

	// 25 MHz clock
	always #20 sys_clk = ~sys_clk;

	slc_lock_ctrl slc_lock_ctrl_i (.sys_clk, .rst_n, .por_n, .wr_req, .flash_secure,
		.auto_erase_cmd, .rom_acc_req, .probe_req, .rom_protect_request,
		.debug_disable_request, .rom_lock, .debug_lock, .rom_acc_grant, .probe_grant,
		.flash_full_erase, .wr_refused);

	// expected lock level from security state and committed bit
	function automatic logic lk(input logic e);
		return flash_secure & e;
	endfunction

	// compare one seen value with its expectation
	task automatic chk(input logic seen, input logic exp, input string msg);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	// one register write, then sample the refused pulse
	task automatic wr(input slc_pkg::slc_sel_t s, input logic [31:0] d, input logic w,
		input logic f);
		@(negedge sys_clk);
		wr_req = '{1'b1, s, w, f, d};
		@(negedge sys_clk);
		wr_req.valid = 1'b0;
		rf = wr_refused;
	endtask

	// random access requests, settle, compare readbacks, locks and grants
	task automatic st;
		rk = $urandom;
		rom_acc_req = rk[0];
		probe_req = rk[1];
		repeat (3) @(negedge sys_clk);
		chk(rom_protect_request, e_rom, "rom readback");
		chk(debug_disable_request, e_dbg, "debug readback");
		chk(rom_lock, lk(e_rom), "rom lock");
		chk(debug_lock, lk(e_dbg), "debug lock");
		chk(rom_acc_grant, rom_acc_req & ~lk(e_rom), "rom grant");
		chk(probe_grant, probe_req & ~lk(e_dbg), "probe grant");
	endtask

	// verdict and end of run
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// watchdog against a hang
	initial
	begin
		#100000;
		miscompares++;
		end_of_test();
	end

	// main sequence
	initial
	begin
		void'($urandom(32'hBA14));
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		por_n = 1'b1;
		st();
		chk(rom_protect_request, 1'b1, "rom power-up bit");
		chk(debug_disable_request, 1'b1, "debug power-up bit");
		$display("test power-up done");
		wr(slc_pkg::SLC_SEL_DBG_MODE, 32'h0, 1'b1, 1'b0);
		wr(slc_pkg::SLC_SEL_DBG_KEY, 32'h0000_00C5, 1'b1, 1'b0);
		e_dbg = 1'b0;
		st();
		@(negedge sys_clk);
		rst_n = 1'b0;
		@(negedge sys_clk);
		rst_n = 1'b1;
		st();
		$display("test debug release done");
		wr(slc_pkg::SLC_SEL_DBG_MODE, 32'h1, 1'b1, 1'b0);
		repeat (20)
		begin
			rk = $urandom;
			if (rk == 32'h0000_00C5)
				rk = ~rk;
			wr(slc_pkg::SLC_SEL_DBG_KEY, rk, 1'b1, 1'b0);
			chk(rf, 1'b1, "wrong debug key taken");
		end
		st();
		wr(slc_pkg::SLC_SEL_DBG_KEY, 32'h0000_00C5, 1'b1, 1'b0);
		e_dbg = 1'b1;
		st();
		$display("test debug re-arm done");
		wr(slc_pkg::SLC_SEL_ROM_ARM, 32'h0, 1'b1, 1'b0);
		chk(rf, 1'b1, "rom write from outside rom");
		wr(slc_pkg::SLC_SEL_ROM_KEY, 32'h0000_003D, 1'b1, 1'b0);
		chk(rf, 1'b1, "rom key from outside rom");
		wr(slc_pkg::SLC_SEL_ROM_ARM, 32'h0, 1'b0, 1'b1);
		chk(rf, 1'b1, "narrow write taken");
		st();
		wr(slc_pkg::SLC_SEL_ROM_ARM, 32'h0, 1'b1, 1'b1);
		chk(rf, 1'b0, "good request refused");
		wr(slc_pkg::SLC_SEL_ROM_KEY, 32'h0000_003D, 1'b1, 1'b1);
		e_rom = 1'b0;
		st();
		rk = $urandom | 32'h0000_0100;
		wr(slc_pkg::SLC_SEL_ROM_KEY, rk, 1'b1, 1'b1);
		chk(rf, 1'b1, "wrong rom key taken");
		st();
		wr(slc_pkg::SLC_SEL_ROM_ARM, 32'h1, 1'b1, 1'b0);
		wr(slc_pkg::SLC_SEL_ROM_KEY, 32'h0000_003D, 1'b1, 1'b0);
		e_rom = 1'b1;
		st();
		flash_secure = 1'b0;
		st();
		flash_secure = 1'b1;
		st();
		$display("test rom lock done");
		for (int i = 1; i >= 0; i--)
		begin
			@(negedge sys_clk);
			flash_secure = i[0];
			auto_erase_cmd = 1'b1;
			@(negedge sys_clk);
			auto_erase_cmd = 1'b0;
			chk(flash_full_erase, i[0], "erase pulse");
			@(negedge sys_clk);
			chk(flash_full_erase, 1'b0, "erase pulse length");
		end
		$display("test erase done");
		end_of_test();
	end
endmodule // tb
